// ### tcs_pkg.sv
// package of constants and types for the telemetry calibration sequencer
package tcs_pkg;
	// ==========================================
	// timing
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned START_MS      = 4200;
	localparam int unsigned CYCLE_MS      = 700;
	localparam int unsigned NUM_LEVELS    = 5;
	localparam int unsigned NUM_CYCLES    = 6;
	localparam int unsigned NUM_UNITS     = 6;
	localparam int unsigned NUM_SSB       = 3;
	localparam int unsigned SSB_CYCLES    = 2;
	localparam int unsigned TONE_HZ       = 1700;
	localparam int unsigned START_CYC     = (CLK_HZ / 1000) * START_MS;
	localparam int unsigned STEP_CYC      = ((CLK_HZ / 1000) * CYCLE_MS) / NUM_LEVELS;
	localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);

	// ==========================================
	// level codes: 0.00 1.25 2.50 3.75 5.00 volts
	localparam logic [2:0] LEVEL_ZERO = 3'h0;
	localparam logic [2:0] LEVEL_TOP  = 3'h4;

	// ground-selectable preflight level sources
	localparam logic [2:0] PRE_STAIRCASE = 3'h5;

	// ==========================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ARM   = 3'b010,
		ST_RUN   = 3'b100
	} tcs_state_t;
endpackage

// ### tcs_tone_gen.sv
// square-wave calibration tone generator
`timescale 1ns/1ps
`default_nettype none
module tcs_tone_gen import tcs_pkg::*; #(
	parameter int unsigned HALF_CYC = TONE_HALF_CYC
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control
	input  wire logic run,
	// tone
	output logic      tone
);
	initial begin
		if (HALF_CYC < 1) $error("tone half period must be at least one cycle");
		if (HALF_CYC > 65536) $error("tone half period exceeds the 16-bit counter");
	end

	logic [15:0] cnt_ff;
	logic        tone_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff  <= 16'h0;
			tone_ff <= 1'b0;
		end else if (!run) begin
			cnt_ff  <= 16'h0;
			tone_ff <= 1'b0;
		end else if (cnt_ff == 16'(HALF_CYC - 1)) begin
			cnt_ff  <= 16'h0;
			tone_ff <= ~tone_ff;
		end else begin
			cnt_ff <= cnt_ff + 16'h1;
		end
	end

	assign tone = tone_ff;
endmodule
`default_nettype wire

// ### tcs_sequencer.sv
// telemetry calibration sequencer: staircase, unit selection, sideband selection
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - held 4.2 s start begins preset sequence
// - staircase five levels then zero, 700 ms
// - staircase repeats six times per start
// - each cycle end advances unit enable, the sixth clears it
// - six unit enables, three sideband enables
// - sideband enables one at a time, 1400 ms
// - 1700 Hz tone to enabled sideband
// - in-flight and prelaunch operating modes
// - ground simulated start ORed with flight start
// - preflight ground picks level or staircase
module tcs_sequencer import tcs_pkg::*; #(
	parameter int unsigned START_HOLD_CYC = START_CYC,
	parameter int unsigned STEP_DWELL_CYC = STEP_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// start commands
	input  wire logic       flight_computer_start,
	input  wire logic       ground_support_equipment_start,
	// prelaunch controls
	input  wire logic       prelaunch_mode,
	input  wire logic [2:0] ground_level_sel,
	// calibration bus level code
	output logic      [2:0] cal_level,
	// unit and sideband enables
	output logic      [5:0] unit_enable,
	output logic      [2:0] sideband_enable,
	output logic            sideband_tone,
	// status
	output logic            busy
);
	// ==========================================
	// parameter checks
	initial begin
		if (START_HOLD_CYC < 1) $error("start hold must be at least one cycle");
		if (STEP_DWELL_CYC < 1) $error("step dwell must be at least one cycle");
	end

	tcs_state_t  state_ff;
	tcs_state_t  nxt_state;
	logic [31:0] start_cnt_ff;
	logic [31:0] dwell_cnt_ff;
	logic [2:0]  step_ff;
	logic [2:0]  cycle_ff;
	logic [2:0]  run_level_ff;
	logic [2:0]  cal_level_ff;
	logic [5:0]  unit_en_ff;
	logic [2:0]  ssb_en_ff;
	logic        start_any;
	logic        start_held;
	logic        step_done;
	logic        cycle_done;
	logic        seq_done;

	// ==========================================
	// start qualification
	assign start_any  = flight_computer_start | ground_support_equipment_start;
	assign start_held = start_any && (start_cnt_ff == START_HOLD_CYC - 1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_cnt_ff <= 32'h0;
		end else if (!start_any || state_ff != ST_IDLE) begin
			start_cnt_ff <= 32'h0;
		end else if (start_cnt_ff != START_HOLD_CYC - 1) begin
			start_cnt_ff <= start_cnt_ff + 32'h1;
		end
	end

	// ==========================================
	// sequencing state
	// dwell is equal per step so a cycle spans five dwells
	assign step_done  = (dwell_cnt_ff == STEP_DWELL_CYC - 1);
	assign cycle_done = step_done && (step_ff == 3'(NUM_LEVELS - 1));
	assign seq_done   = cycle_done && (cycle_ff == 3'(NUM_CYCLES - 1));

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_held && !prelaunch_mode) nxt_state = ST_ARM;
				if (start_held && prelaunch_mode) nxt_state = ST_ARM;
			end
			ST_ARM: begin
				nxt_state = ST_RUN;
			end
			ST_RUN: begin
				if (seq_done) nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dwell_cnt_ff <= 32'h0;
			step_ff      <= 3'h0;
			cycle_ff     <= 3'h0;
		end else if (state_ff != ST_RUN) begin
			dwell_cnt_ff <= 32'h0;
			step_ff      <= 3'h0;
			cycle_ff     <= 3'h0;
		end else if (step_done) begin
			dwell_cnt_ff <= 32'h0;
			if (cycle_done) begin
				step_ff  <= 3'h0;
				cycle_ff <= cycle_ff + 3'h1;
			end else begin
				step_ff <= step_ff + 3'h1;
			end
		end else begin
			dwell_cnt_ff <= dwell_cnt_ff + 32'h1;
		end
	end

	// ==========================================
	// free-running staircase for preflight continuous selection
	logic [31:0] pre_cnt_ff;
	logic [2:0]  pre_step_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_cnt_ff  <= 32'h0;
			pre_step_ff <= 3'h0;
		end else if (pre_cnt_ff == STEP_DWELL_CYC - 1) begin
			pre_cnt_ff  <= 32'h0;
			pre_step_ff <= (pre_step_ff == LEVEL_TOP) ? LEVEL_ZERO : pre_step_ff + 3'h1;
		end else begin
			pre_cnt_ff <= pre_cnt_ff + 32'h1;
		end
	end

	// ==========================================
	// calibration bus level
	always_comb begin
		run_level_ff = (state_ff == ST_RUN) ? step_ff : LEVEL_ZERO;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cal_level_ff <= LEVEL_ZERO;
		end else if (state_ff == ST_RUN) begin
			cal_level_ff <= run_level_ff;
		end else if (prelaunch_mode) begin
			// ground holds a fixed step or the continuous staircase
			if (ground_level_sel == PRE_STAIRCASE) begin
				cal_level_ff <= pre_step_ff;
			end else if (ground_level_sel <= LEVEL_TOP) begin
				cal_level_ff <= ground_level_sel;
			end else begin
				cal_level_ff <= LEVEL_ZERO;
			end
		end else begin
			cal_level_ff <= LEVEL_ZERO;
		end
	end

	// ==========================================
	// unit and sideband selection
	// registered enables change on the same edge the step counter wraps
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			unit_en_ff <= 6'h0;
			ssb_en_ff  <= 3'h0;
		end else if (state_ff == ST_ARM) begin
			unit_en_ff <= 6'h01;
			ssb_en_ff  <= 3'h1;
		end else if (state_ff == ST_RUN && seq_done) begin
			unit_en_ff <= 6'h0;
			ssb_en_ff  <= 3'h0;
		end else if (state_ff == ST_RUN && cycle_done) begin
			unit_en_ff <= {unit_en_ff[4:0], 1'b0};
			if (cycle_ff[0]) begin
				ssb_en_ff <= {ssb_en_ff[1:0], 1'b0};
			end
		end
	end

	tcs_tone_gen #(
		.HALF_CYC (TONE_HALF_CYC)
	) u_tone (
		.clk  (clk),
		.rst  (rst),
		.run  (|ssb_en_ff),
		.tone (sideband_tone)
	);

	assign cal_level       = cal_level_ff;
	assign unit_enable     = unit_en_ff;
	assign sideband_enable = ssb_en_ff;
	assign busy            = (state_ff != ST_IDLE);
endmodule
`default_nettype wire

// ### tcs_properties.sv
// port checker for the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module tcs_properties import tcs_pkg::*; #(
	parameter int unsigned START_HOLD_CYC = 10,
	parameter int unsigned STEP_DWELL_CYC = 4
) (
	// clock, reset, inputs
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       flight_computer_start,
	input wire logic       ground_support_equipment_start,
	// outputs
	input wire logic [2:0] cal_level,
	input wire logic [5:0] unit_enable,
	input wire logic [2:0] sideband_enable,
	input wire logic       sideband_tone,
	input wire logic       busy
);
	// ==========================================
	localparam int HOLD = START_HOLD_CYC - 1;
	localparam int UNIT = 5 * STEP_DWELL_CYC - 1;
	localparam int SSB  = 10 * STEP_DWELL_CYC - 1;
	wire start_any = flight_computer_start | ground_support_equipment_start;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence unit_hold;
		##UNIT unit_enable[1] ##1 unit_enable[2];
	endsequence
	sequence ssb_hold;
		##SSB sideband_enable[1] ##1 sideband_enable[2];
	endsequence
	unit_one_hot_a: assert property ($onehot0(unit_enable)) else $error("unit enables");
	ssb_one_hot_a: assert property ($onehot0(sideband_enable)) else $error("sideband enables");
	idle_quiet_a: assert property (!busy |-> unit_enable == 0 && sideband_enable == 0)
		else $error("enable while idle");
	unit_dwell_a: assert property ($rose(unit_enable[1]) |-> unit_hold) else $error("unit span");
	ssb_span_a: assert property ($rose(sideband_enable[1]) |-> ssb_hold) else $error("ssb span");
	unit_advance_a: assert property ($changed(unit_enable) && unit_enable != 0
		&& $past(unit_enable) != 0 |-> unit_enable == $past(unit_enable) << 1) else $error("unit order");
	level_step_a: assert property (busy && $changed(cal_level) && cal_level != 0
		|-> cal_level == $past(cal_level) + 3'h1 && cal_level <= LEVEL_TOP) else $error("level");
	start_hold_a: assert property ($rose(busy) |-> $past(start_any, HOLD) && $past(start_any))
		else $error("short start");
	tone_gate_a: assert property (sideband_tone |-> $past(sideband_enable) != 0) else $error("tone");
	last_unit_a: assert property ($fell(busy) |-> $past(unit_enable[5])) else $error("cycles");
endmodule
`default_nettype wire

// ### tcs_far_side.sv
// far-side model: flight start command and first telemeter
`timescale 1ns/1ps
`default_nettype none
module tcs_far_side import tcs_pkg::*; #(
	parameter int unsigned HOLD = 10
) (
	// control
	input wire logic       clk,
	input wire logic       fire,
	// unit side
	input wire logic       unit_on,
	input wire logic       mux_on,
	input wire logic [2:0] level,
	output logic           start,
	output logic     [2:0] tm_data,
	output logic     [2:0] mux_data
);
	// ==========================================
	int unsigned cnt = 0;
	always @(negedge clk) begin
		if (fire && cnt == 0) cnt <= HOLD + 3;
		else if (cnt != 0) cnt <= cnt - 1;
	end
	assign start = cnt != 0;
	// normal data sits on an unused code so substitution shows
	assign tm_data = unit_on ? level : 3'h7;

	// ==========================================
	// multiplexer: four-clock master frame, own staircase
	logic [1:0] frame_cnt = 2'h0;
	logic       mux_arm   = 1'b0;
	logic       mux_run   = 1'b0;
	logic [2:0] mux_lvl   = 3'h0;
	always @(posedge clk) begin
		frame_cnt <= frame_cnt + 2'h1;
		if (mux_on && !mux_run && !mux_arm) mux_arm <= 1'b1;
		if (frame_cnt == 2'h3 && mux_arm) begin
			mux_arm <= 1'b0;
			mux_run <= 1'b1;
			mux_lvl <= 3'h0;
		end else if (frame_cnt == 2'h3 && mux_run) begin
			if (mux_lvl == LEVEL_TOP) mux_run <= 1'b0;
			else mux_lvl <= mux_lvl + 3'h1;
		end
	end
	assign mux_data = mux_run ? mux_lvl : 3'h7;
endmodule
`default_nettype wire

// ### test_telemetry_calibration_sequencer.sv
// testbench for the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module test_telemetry_calibration_sequencer import tcs_pkg::*;;
	// ==========================================
	logic clk, rst, fire, gse, pre, fcs, tone, busy;
	logic [2:0] sel, lvl, se, tm;
	logic [5:0] ue;
	int n_errors = 0, n_tests = 0, cyc = 0;
	tcs_sequencer #(.START_HOLD_CYC(10), .STEP_DWELL_CYC(4)) DUT (.clk(clk), .rst(rst),
		.flight_computer_start(fcs), .ground_support_equipment_start(gse),
		.prelaunch_mode(pre), .ground_level_sel(sel), .cal_level(lvl),
		.unit_enable(ue), .sideband_enable(se), .sideband_tone(tone), .busy(busy));
	tcs_far_side #(.HOLD(10)) u_far (.clk(clk), .fire(fire), .unit_on(ue[0]),
		.mux_on(ue[1]), .level(lvl), .start(fcs), .tm_data(tm), .mux_data());
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic t_short;
		gse = 1;
		repeat (9) @(negedge clk);
		gse = 0;
		repeat (5) @(negedge clk);
		check("busy", 8'(busy), 8'h0);
		$display("t_short done");
	endtask
	task automatic t_run;
		fire <= 1;
		@(negedge clk);
		fire <= 0;
		for (int i = 0; i < 40 && ue == 0; i++) @(negedge clk);
		repeat (2) @(negedge clk);
		for (int k = 0; k < 30; k++) begin
			check("level", 8'(lvl), 8'(k % 5));
			check("unit", 8'(ue), 8'(1 << (k / 5)));
			check("sideband", 8'(se), 8'(1 << (k / 10)));
			check("tm", 8'(tm), k < 5 ? 8'(k) : 8'h7);
			repeat (4) @(negedge clk);
		end
		repeat (4) @(negedge clk);
		check("end", {busy, se, ue[3:0]}, 8'h0);
		check("end unit", 8'(ue), 8'h0);
		check("tone off", 8'(tone), 8'h0);
		$display("t_run done");
	endtask
	task automatic t_pre;
		logic [2:0] prev;
		pre = 1;
		for (int s = 0; s < 8; s++) begin
			sel = 3'(s);
			repeat (3) @(negedge clk);
			if (s != 5) check("preset", 8'(lvl), s < 5 ? 8'(s) : 8'h0);
		end
		sel = PRE_STAIRCASE;
		@(negedge clk);
		prev = lvl;
		repeat (5) @(negedge clk);
		check("stairs", 8'(lvl != prev), 8'h1);
		$display("t_pre done");
	endtask
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		{rst, fire, gse, pre, sel} = 7'h40;
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst = 0;
		t_short();
		t_run();
		t_pre();
		end_sim();
	end
endmodule
bind tcs_sequencer tcs_properties #(.START_HOLD_CYC(START_HOLD_CYC),
	.STEP_DWELL_CYC(STEP_DWELL_CYC)) u_props (.clk, .rst, .flight_computer_start,
	.ground_support_equipment_start, .cal_level, .unit_enable, .sideband_enable,
	.sideband_tone, .busy);
`default_nettype wire
